// file: core/lfs_pkg.sv
package lfs_pkg;

	// clock and converter timing
	localparam int unsigned CLK_FREQ_KHZ  = 250000;
	localparam int unsigned OSC_FREQ_KHZ  = 300;
	localparam int unsigned OSC_DIV_CYC   = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
	localparam int unsigned SYNC_IDLE_US  = 30;
	localparam int unsigned SYNC_IDLE_CYC = (SYNC_IDLE_US * CLK_FREQ_KHZ + 999) / 1000;
	localparam int unsigned LATCH_COUNT   = 32770;

	// widths
	localparam int unsigned CH_N   = 2;
	localparam int unsigned CNT_W  = 16;
	localparam int unsigned OSC_W  = 10;
	localparam int unsigned IDLE_W = 16;
	localparam int unsigned SYN_W  = 18;

	// synchronised input vector field positions
	localparam int unsigned SY_CMP_LSB  = 0;
	localparam int unsigned SY_PWM      = 13;
	localparam int unsigned SY_SYNC     = 14;
	localparam int unsigned SY_EN       = 15;
	localparam int unsigned SY_SEL      = 16;
	localparam int unsigned SY_SEL_DRV  = 17;

	// reset value of the whole state
	localparam logic [3:0] RST_ZERO = 4'h0;

	// comparator results from the analog front end
	typedef struct packed {
		logic            reg_out_low;   // regulator below 4.0V
		logic            reg_out_ok;    // regulator above 4.5V
		logic            tj_hot;        // junction above 175C
		logic            tj_cool;       // junction below 150C
		logic            fb_over;       // feedback above 2.0V
		logic            fb_over_rel;   // feedback below 1.45V
		logic            cs_overcur;    // sense at or below supply-0.6V
		logic            fb_open_lvl;   // feedback at or above 1.7V
		logic            fb_short_lvl;  // feedback at or below 1.6V
		logic [CH_N-1:0] led_low;       // led pin at or below 0.3V
		logic [CH_N-1:0] led_high;      // led pin at or above 4.5V
	} lfs_cmp_t;

	// complete supervisor state
	typedef struct packed {
		logic                       uv_lock;
		logic                       therm;
		logic                       overv;
		logic                       ext_mode;
		logic                       sync_prev;
		logic [IDLE_W-1:0]          idle_cnt;
		logic [OSC_W-1:0]           osc_cnt;
		logic                       tick;
		logic [CNT_W-1:0]           gnd_cnt;
		logic                       gnd_lat;
		logic [CH_N-1:0]            open_lat;
		logic [CH_N-1:0]            short_lat;
		logic [CH_N-1:0][CNT_W-1:0] short_cnt;
		logic [CH_N-1:0]            drv_en;
		logic                       conv_run;
		logic                       ss_dis;
		logic                       sys_fault_oe;
		logic                       led_fault_oe;
		logic                       int_osc;
	} lfs_state_t;

endpackage

// file: core/lfs_supervisor.sv
// Functional notes
// RULE_01 - select low enables both channels; high keeps channel one, turns channel two off
// RULE_02 - undriven channel select input reads as low
// RULE_03 - enabled channel with nothing attached still gets open detection
// RULE_04 - each enabled driver follows the pwm input level directly
// RULE_05 - controller holds pwm high when dimming is not used
// RULE_06 - controller keeps channel select steady during pwm dimming
// RULE_07 - converter switches only while at least one led output is active
// RULE_08 - system flag low on lockout, thermal, overvoltage, ground short; led flag on open/short
// RULE_09 - regulator lockout below 4.0V, release above 4.5V, stops all but regulator
// RULE_10 - thermal shutdown above 175C, release below 150C
// RULE_11 - overcurrent discharges soft-start and stops switching, recovers by itself
// RULE_12 - overvoltage above 2.0V discharges soft-start, stops switching, releases below 1.45V
// RULE_13 - led pin below 0.3V starts counter; expiry latches everything but regulator off
// RULE_14 - ground short counter clears if led pin recovers before expiry
// RULE_15 - led low with feedback at or above 1.7V latches that channel off at once
// RULE_16 - led high with feedback at or below 1.6V counts, then latches that channel off
// RULE_17 - short detection and counting only while pwm is high
// RULE_18 - short counter returns to zero if condition vanishes before expiry
// RULE_19 - delay counters tick at switching rate, latch at count 32770
// RULE_20 - latches clear only by enable going low or regulator lockout
// RULE_21 - sync rising edges only; internal oscillator resumes 30us after edges stop; code counts only sync-low time, so sync held high never falls back
// RULE_22 - controller never syncs slower than internal, nor drops to internal mid-sync
// RULE_23 - controller enables after supply and dimming level, sync and pwm after 4.6V
// RULE_24 - comparators, pwm and sync pass two flip-flops before use
`timescale 1ns/100ps
module lfs_supervisor #(
	parameter int unsigned SYNC_IDLE_CYC = lfs_pkg::SYNC_IDLE_CYC,
	parameter int unsigned LATCH_COUNT   = lfs_pkg::LATCH_COUNT
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       ce_i,
	input  wire logic                       enable_i,
	input  wire logic                       chan_sel_i,
	input  wire logic                       chan_sel_drv_i,
	input  wire logic                       pwm_i,
	input  wire logic                       sync_i,
	input  wire lfs_pkg::lfs_cmp_t          cmp_i,
	output logic      [lfs_pkg::CH_N-1:0]   led_drv_en_o,
	output logic                            conv_run_o,
	output logic                            ss_discharge_o,
	output logic                            switch_tick_o,
	output logic                            int_osc_o,
	output logic                            sys_fault_o,
	output logic                            sys_fault_oe_o,
	output logic                            led_fault_o,
	output logic                            led_fault_oe_o
);

	localparam logic [lfs_pkg::OSC_W-1:0]  OSC_LAST  =
		lfs_pkg::OSC_W'(lfs_pkg::OSC_DIV_CYC - 1);
	localparam logic [lfs_pkg::IDLE_W-1:0] IDLE_LAST =
		lfs_pkg::IDLE_W'(SYNC_IDLE_CYC - 1);
	localparam logic [lfs_pkg::CNT_W-1:0]  CNT_LAST  =
		lfs_pkg::CNT_W'(LATCH_COUNT);

	lfs_pkg::lfs_state_t state_reg;
	lfs_pkg::lfs_state_t state_next;

	logic [lfs_pkg::SYN_W-1:0] raw_in;
	logic [lfs_pkg::SYN_W-1:0] syn_in;
	lfs_pkg::lfs_cmp_t         cmp_s;
	logic                      pwm_s;
	logic                      sync_s;
	logic                      en_s;
	logic                      sel_s;

	// all asynchronous levels cross through one two-stage bank
	assign raw_in = {chan_sel_drv_i, chan_sel_i, enable_i, sync_i, pwm_i, cmp_i};

	lfs_sync2 #(
		.W (lfs_pkg::SYN_W)
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.d_i       (raw_in),
		.q_o       (syn_in)
	); // RULE_24

	// unpack the synchronised vector
	assign cmp_s  = syn_in[lfs_pkg::SY_PWM-1:lfs_pkg::SY_CMP_LSB];
	assign pwm_s  = syn_in[lfs_pkg::SY_PWM];
	assign sync_s = syn_in[lfs_pkg::SY_SYNC];
	assign en_s   = syn_in[lfs_pkg::SY_EN];
	// a floating select pin is pulled down inside the pad
	assign sel_s  = syn_in[lfs_pkg::SY_SEL_DRV] & syn_in[lfs_pkg::SY_SEL]; // RULE_02

	// channel enable from the select pin
	function automatic logic [lfs_pkg::CH_N-1:0] chan_map(input logic sel);
		chan_map = {~sel, 1'b1};
	endfunction

	// a channel is alive while selected, unlatched and not shut down
	function automatic logic [lfs_pkg::CH_N-1:0] alive_map(
		input logic                     sel,
		input logic                     down,
		input logic [lfs_pkg::CH_N-1:0] open_l,
		input logic [lfs_pkg::CH_N-1:0] short_l
	);
		alive_map = chan_map(sel) & ~open_l & ~short_l & {lfs_pkg::CH_N{~down}};
	endfunction

	logic                     clear_all;
	logic                     shutdown;
	logic [lfs_pkg::CH_N-1:0] alive;
	logic                     sync_rise;

	// latches drop only with enable low or a lockout
	assign clear_all = ~en_s | state_reg.uv_lock; // RULE_20
	assign shutdown  = clear_all | state_reg.therm | state_reg.gnd_lat; // RULE_09 RULE_10
	assign alive     = alive_map(sel_s, shutdown, state_reg.open_lat,
		state_reg.short_lat); // RULE_01 RULE_03
	// edge detector reads only the second stage
	assign sync_rise = sync_s & ~state_reg.sync_prev; // RULE_21

	// next-state logic for the whole supervisor
	always_comb
	begin
		logic                     any_low;
		logic [lfs_pkg::CH_N-1:0] alive_n;
		logic                     down_n;
		state_next = state_reg;
		any_low    = 1'b0;
		alive_n    = '0;
		down_n     = 1'b0;

		// lockout with hysteresis from two comparators
		if (cmp_s.reg_out_low)
			state_next.uv_lock = 1'b1; // RULE_09
		else if (cmp_s.reg_out_ok)
			state_next.uv_lock = 1'b0; // RULE_09

		// thermal shutdown with hysteresis
		if (cmp_s.tj_hot)
			state_next.therm = 1'b1; // RULE_10
		else if (cmp_s.tj_cool)
			state_next.therm = 1'b0; // RULE_10

		// overvoltage holds until feedback falls well below trip
		if (cmp_s.fb_over)
			state_next.overv = 1'b1; // RULE_12
		else if (cmp_s.fb_over_rel)
			state_next.overv = 1'b0; // RULE_12

		// sync edge tracking and fallback to internal oscillation
		state_next.sync_prev = sync_s;
		if (sync_rise)
		begin
			state_next.ext_mode = 1'b1; // RULE_21
			state_next.idle_cnt = '0;
		end
		else if (sync_s)
			state_next.idle_cnt = '0;
		else if (state_reg.ext_mode)
		begin
			if (state_reg.idle_cnt == IDLE_LAST)
			begin
				state_next.ext_mode = 1'b0; // RULE_21
				state_next.idle_cnt = '0;
			end
			else
				state_next.idle_cnt = state_reg.idle_cnt + 1'b1;
		end

		// internal oscillator free-runs so the switch back is seamless
		if (state_reg.osc_cnt == OSC_LAST)
			state_next.osc_cnt = '0;
		else
			state_next.osc_cnt = state_reg.osc_cnt + 1'b1;

		// switching tick, the clock of every delay counter
		if (state_reg.ext_mode)
			state_next.tick = sync_rise; // RULE_19
		else
			state_next.tick = (state_reg.osc_cnt == OSC_LAST); // RULE_19

		// ground short: any alive led pin low starts the delay
		any_low = |(alive & cmp_s.led_low);
		if (clear_all)
		begin
			state_next.gnd_cnt = '0; // RULE_20
			state_next.gnd_lat = 1'b0; // RULE_20
		end
		else if (!any_low)
			state_next.gnd_cnt = '0; // RULE_14
		else if (state_reg.tick && !state_reg.gnd_lat)
		begin
			state_next.gnd_cnt = state_reg.gnd_cnt + 1'b1; // RULE_13
			if (state_next.gnd_cnt == CNT_LAST)
			begin
				state_next.gnd_lat = 1'b1; // RULE_13 RULE_19
				state_next.gnd_cnt = '0;
			end
		end

		// per-channel open and short detection
		for (int i = 0; i < lfs_pkg::CH_N; i++)
		begin
			if (clear_all)
			begin
				state_next.open_lat[i]  = 1'b0; // RULE_20
				state_next.short_lat[i] = 1'b0; // RULE_20
				state_next.short_cnt[i] = '0;
			end
			else
			begin
				// open latches at once, no counter
				if (alive[i] && cmp_s.led_low[i] && cmp_s.fb_open_lvl)
					state_next.open_lat[i] = 1'b1; // RULE_15 RULE_03
				// short counting pauses while pwm is low
				if (!alive[i])
					state_next.short_cnt[i] = '0;
				else if (pwm_s)
				begin
					if (!(cmp_s.led_high[i] && cmp_s.fb_short_lvl))
						state_next.short_cnt[i] = '0; // RULE_18
					else if (state_reg.tick)
					begin
						state_next.short_cnt[i] = state_reg.short_cnt[i] + 1'b1; // RULE_16
						if (state_next.short_cnt[i] == CNT_LAST)
						begin
							state_next.short_lat[i] = 1'b1; // RULE_16 RULE_19
							state_next.short_cnt[i] = '0;
						end
					end
				end // RULE_17
			end
		end

		// outputs from the updated latches so they act one edge after detection;
		// lockout is taken from the next state as well, otherwise switching would
		// run one extra cycle while the system flag already reports the lockout
		down_n  = ~en_s | state_next.uv_lock | state_next.therm | state_next.gnd_lat; // RULE_09
		alive_n = alive_map(sel_s, down_n, state_next.open_lat, state_next.short_lat);
		state_next.drv_en   = alive_n & {lfs_pkg::CH_N{pwm_s}}; // RULE_04
		// switching stops while no output is alive or a limit is hit
		state_next.conv_run = (|alive_n) & ~state_next.overv & ~cmp_s.cs_overcur; // RULE_07 RULE_11 RULE_12
		state_next.ss_dis   = state_next.overv | cmp_s.cs_overcur | down_n; // RULE_11 RULE_12
		state_next.int_osc  = ~state_next.ext_mode;

		// open-drain flags pull low while their condition stands
		state_next.sys_fault_oe = state_next.uv_lock | state_next.therm |
			state_next.overv | state_next.gnd_lat; // RULE_08
		state_next.led_fault_oe = (|state_next.open_lat) |
			(|state_next.short_lat); // RULE_08
	end

	// single state register, frozen while clock enable is low
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			state_reg <= '0;
		else if (ce_i)
			state_reg <= state_next;
	end

	// every output but the two fault pins straight from the state register
	assign led_drv_en_o   = state_reg.drv_en;
	assign conv_run_o     = state_reg.conv_run;
	assign ss_discharge_o = state_reg.ss_dis;
	assign switch_tick_o  = state_reg.tick;
	assign int_osc_o      = state_reg.int_osc;
	assign sys_fault_oe_o = state_reg.sys_fault_oe;
	assign led_fault_oe_o = state_reg.led_fault_oe;
	// open drain: driven value is always low, the enable decides
	assign sys_fault_o    = 1'b0;
	assign led_fault_o    = 1'b0;

endmodule // lfs_supervisor

// file: core/lfs_sync2.sv
`timescale 1ns/100ps
module lfs_sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// first stage feeds only the second stage
	always_comb
	begin
		meta_next = d_i;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			meta_reg <= '0;
			q_reg    <= '0;
		end
		else if (ce_i)
		begin
			meta_reg <= meta_next;
			q_reg    <= q_next;
		end
	end

	assign q_o = q_reg;

endmodule // lfs_sync2

// file: tb/led_fault_supervisor_bench.sv
`timescale 1ns/100ps
module led_fault_supervisor_bench;
	logic              clk_sys_i = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic              sel = 1'b0, sel_drv = 1'b1, en_req = 1'b0;
	logic              ce = 1'b1, tick;
	logic              dim = 1'b0, dim_lvl = 1'b0, sync_run = 1'b0;
	lfs_pkg::lfs_cmp_t cmp = '0;
	wire logic         enable, pwm, sync;
	logic [1:0]        drv;
	logic              run, ssd, iosc, sfoe, lfoe;
	int                n_fail = 0, total_checks = 0, cyc = 0, gap = 0;
	int                set_b [4] = '{12, 10, 8, 6};
	int                rel_b [4] = '{11, 9, 7, 6};
	logic [5:0]        want [4] = '{6'h14, 6'h14, 6'h17, 6'h07};
	wire logic [5:0]   st = {lfoe, sfoe, run, ssd, drv};

	always #2 clk_sys_i = ~clk_sys_i;
	lfs_host_model host_u (.clk_sys_i, .en_req_i(en_req), .dim_i(dim), .dim_lvl_i(dim_lvl),
		.sync_run_i(sync_run), .enable_o(enable), .pwm_o(pwm), .sync_o(sync));
	// short latch count; fallback wait outlasts the 20-clock low half of the host sync
	lfs_supervisor #(.SYNC_IDLE_CYC(30), .LATCH_COUNT(4)) dut_u (.clk_sys_i, .sys_rst_i,
		.ce_i(ce), .enable_i(enable), .chan_sel_i(sel), .chan_sel_drv_i(sel_drv),
		.pwm_i(pwm), .sync_i(sync), .cmp_i(cmp), .led_drv_en_o(drv), .conv_run_o(run),
		.ss_discharge_o(ssd), .switch_tick_o(tick), .int_osc_o(iosc), .sys_fault_o(),
		.sys_fault_oe_o(sfoe), .led_fault_o(), .led_fault_oe_o(lfoe));

	task automatic step(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// hang guard: the run needs about 10000 cycles
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			results();
		end
	end
	// select changes only while not dimming
	initial
	begin
		step(8);
		sys_rst_i = 1'b0;
		en_req = 1'b1;
		step(22);
		chk(st, 6'h0b);
		// clock enable low freezes synchronisers and state alike
		ce = 1'b0;
		sel = 1'b1;
		step(5);
		chk(st, 6'h0b);
		ce = 1'b1;
		step(5);
		chk(st, 6'h09);
		sel_drv = 1'b0;
		step(5);
		chk(st, 6'h0b);
		sel = 1'b0;
		sel_drv = 1'b1;
		dim = 1'b1;
		step(5);
		chk(st, 6'h08);
		dim = 1'b0;
		// each protection: applied, held after its cause fades (except overcurrent, which clears at once), then released
		for (int i = 0; i < 4; i++)
		begin
			cmp[set_b[i]] = 1'b1;
			step(5);
			chk(st, want[i]);
			cmp[set_b[i]] = 1'b0;
			step(5);
			chk(st, (i == 3) ? 6'h0b : want[i]);
			if (i < 3) cmp[rel_b[i]] = 1'b1;
			step(5);
			chk(st, 6'h0b);
			if (i < 3) cmp[rel_b[i]] = 1'b0;
		end
		cmp.led_low[0] = 1'b1;
		cmp.fb_open_lvl = 1'b1;
		step(5);
		chk(st, 6'h2a);
		cmp = '0;
		step(5);
		chk(st, 6'h2a);
		en_req = 1'b0;
		step(5);
		chk(st, 6'h04);
		en_req = 1'b1;
		sync_run = 1'b1;
		step(100);
		chk({5'h00, iosc}, 6'h00);
		chk(st, 6'h0b);
		// exactly three sync ticks, one short of the latch
		cmp.led_high[1] = 1'b1;
		cmp.fb_short_lvl = 1'b1;
		step(120);
		cmp = '0;
		step(5);
		chk(st, 6'h0b);
		cmp.led_high[1] = 1'b1;
		cmp.fb_short_lvl = 1'b1;
		// one more tick: a count not cleared above would latch here
		step(40);
		dim = 1'b1;
		step(300);
		dim = 1'b0;
		step(5);
		chk(st, 6'h0b);
		step(200);
		chk(st, 6'h29);
		cmp = '0;
		sync_run = 1'b0;
		step(70);
		chk({5'h00, iosc}, 6'h01);
		// internal tick period, counted from one pulse to the next
		while (tick !== 1'b1) step(1);
		gap = 1;
		step(1);
		while (tick !== 1'b1)
		begin
			gap++;
			step(1);
		end
		chk({5'h00, gap == lfs_pkg::OSC_DIV_CYC}, 6'h01);
		en_req = 1'b0;
		step(5);
		en_req = 1'b1;
		step(22);
		// exactly three internal ticks, one short of the latch
		cmp.led_low[1] = 1'b1;
		step(3 * lfs_pkg::OSC_DIV_CYC);
		cmp = '0;
		step(5);
		chk(st, 6'h0b);
		// a count not cleared would latch within this stretch
		cmp.led_low[1] = 1'b1;
		step(900);
		chk(st, 6'h0b);
		step(3400);
		chk(st, 6'h14);
		results();
	end
endmodule // led_fault_supervisor_bench

// file: tb/lfs_host_model.sv
`timescale 1ns/100ps
module lfs_host_model (
	input  wire logic clk_sys_i,
	input  wire logic en_req_i,
	input  wire logic dim_i,
	input  wire logic dim_lvl_i,
	input  wire logic sync_run_i,
	output logic      enable_o,
	output logic      pwm_o,
	output logic      sync_o
);
	// stand-in for the regulator settling before pwm and sync may start
	logic [3:0] up_reg   = 4'h0;
	logic [4:0] div_reg  = 5'h00;
	logic       sync_reg = 1'b0;
	assign enable_o = en_req_i;
	assign pwm_o    = (up_reg == 4'hf) && (!dim_i || dim_lvl_i);
	assign sync_o   = sync_reg;
	// 40-clock sync period, far faster than the internal rate; stops low
	always @(negedge clk_sys_i)
	begin
		up_reg  <= !en_req_i ? 4'h0 : (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
		div_reg <= (div_reg == 5'h13) ? 5'h00 : div_reg + 5'h01;
		if (div_reg == 5'h13) sync_reg <= sync_run_i && (up_reg == 4'hf) && !sync_reg;
	end
endmodule // lfs_host_model

// file: tb/lfs_supervisor_checker.sv
`timescale 1ns/100ps
module lfs_supervisor_checker #(
	parameter int unsigned SYNC_IDLE_CYC = 20,
	parameter int unsigned LATCH_COUNT   = 4
) (
	input wire logic                     clk_sys_i,
	input wire logic                     sys_rst_i,
	input wire logic                     ce_i,
	input wire logic                     enable_i,
	input wire logic                     chan_sel_i,
	input wire logic                     chan_sel_drv_i,
	input wire logic                     pwm_i,
	input wire logic                     sync_i,
	input wire lfs_pkg::lfs_cmp_t        cmp_i,
	input wire logic [lfs_pkg::CH_N-1:0] led_drv_en_o,
	input wire logic                     conv_run_o,
	input wire logic                     ss_discharge_o,
	input wire logic                     switch_tick_o,
	input wire logic                     int_osc_o,
	input wire logic                     sys_fault_o,
	input wire logic                     sys_fault_oe_o,
	input wire logic                     led_fault_o,
	input wire logic                     led_fault_oe_o
);
	// $past reaches three edges back: those edges must follow reset with clock enable high
	logic [2:0] up_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || !ce_i) up_reg <= 3'h0;
		else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
	end
	wire logic up = (up_reg == 3'h7) && ce_i;
	// helpers so that each $past samples a single signal
	wire logic sel_off   = chan_sel_i && chan_sel_drv_i;
	wire logic led_cause = |(cmp_i.led_low | cmp_i.led_high);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	chan_two_off_a: assert property (up && $past(sel_off, 3)
		|-> !led_drv_en_o[1]) else $error("channel two on while deselected");
	pwm_gate_a: assert property (up && !$past(pwm_i, 3) |-> led_drv_en_o == 2'h0)
		else $error("driver on with pwm low");
	lockout_off_a: assert property (up && $past(cmp_i.reg_out_low, 3)
		|-> sys_fault_oe_o && !conv_run_o) else $error("lockout not applied");
	thermal_off_a: assert property (up && $past(cmp_i.tj_hot, 3)
		|-> sys_fault_oe_o && led_drv_en_o == 2'h0) else $error("thermal not applied");
	overcur_stop_a: assert property (up && $past(cmp_i.cs_overcur, 3)
		|-> ss_discharge_o && !conv_run_o) else $error("overcurrent not applied");
	overvolt_stop_a: assert property (up && $past(cmp_i.fb_over, 3)
		|-> ss_discharge_o && !conv_run_o && sys_fault_oe_o) else $error("overvoltage missed");
	disabled_idle_a: assert property (up && !$past(enable_i, 3)
		|-> !conv_run_o && led_drv_en_o == 2'h0) else $error("running while disabled");
	flag_value_a: assert property (!sys_fault_o && !led_fault_o)
		else $error("fault pin driven high");
	led_flag_cause_a: assert property (up && $rose(led_fault_oe_o)
		|-> $past(led_cause, 3)) else $error("led flag without cause");
	tick_pulse_a: assert property (switch_tick_o && ce_i |=> !switch_tick_o)
		else $error("tick longer than one cycle");
	ext_sync_c: cover property (!int_osc_o && switch_tick_o);
	led_latch_c: cover property ($rose(led_fault_oe_o));
	sys_latch_c: cover property ($rose(sys_fault_oe_o) && ss_discharge_o);
endmodule // lfs_supervisor_checker

bind lfs_supervisor lfs_supervisor_checker #(
	.SYNC_IDLE_CYC(SYNC_IDLE_CYC), .LATCH_COUNT(LATCH_COUNT)
) chk_u (.clk_sys_i, .sys_rst_i, .ce_i, .enable_i, .chan_sel_i, .chan_sel_drv_i, .pwm_i,
	.sync_i, .cmp_i, .led_drv_en_o, .conv_run_o, .ss_discharge_o, .switch_tick_o,
	.int_osc_o, .sys_fault_o, .sys_fault_oe_o, .led_fault_o, .led_fault_oe_o);
